// ==== core/ccmc_mode_ctrl.sv ====
`timescale 1ns/1ps
module ccmc_mode_ctrl #(
  parameter int unsigned CNT_W = ccmc_pkg::CNT_W
) (
  // clock, reset and clock enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // mode word written by software
  input wire logic [ccmc_pkg::MODE_W-1:0] counter_array_mode_reg_i,
  // shared counter and this module's compare value
  input wire logic [CNT_W-1:0] count_i,
  input wire logic count_tick_i,
  input wire logic [CNT_W-1:0] compare_i,
  // software clear of the flag
  input wire logic flag_clr_i,
  // module pin
  input wire logic module_io_pin_i,
  output logic module_io_pin_o,
  output logic module_io_pin_oe_o,
  // flag, interrupt request and capture result
  output logic capcomp_flag_o,
  output logic irq_req_o,
  output ccmc_pkg::ccmc_capture_s capture_o
);

  // the narrow pwm and frequency step need a low byte and a separate high byte, so the width is fixed at 16
  if (CNT_W != ccmc_pkg::CNT_W) begin : g_width_check
    $error("ccmc_mode_ctrl: counter width must be 16");
  end

  localparam int unsigned NW = ccmc_pkg::NARROW_W; // narrow field width

  ccmc_pkg::ccmc_mode_s mode; // unpacked mode word
  ccmc_pkg::ccmc_fn_e fn_q; // output function in force
  ccmc_pkg::ccmc_fn_e fn_d; // decoded function for the next cycle
  logic pin_q; // level driven on the module pin
  logic pin_d; // next pin level
  logic flag_q; // capture/compare flag
  logic flag_d; // next flag
  logic [NW-1:0] freq_next_q; // next low-byte match point in frequency mode
  logic [NW-1:0] freq_next_d; // its next value
  ccmc_pkg::ccmc_capture_s cap_q; // captured value and strobe
  ccmc_pkg::ccmc_capture_s cap_d; // next capture state
  logic pin_rise; // rising edge on the module pin
  logic pin_fall; // falling edge on the module pin
  logic cap_hit; // an enabled capture edge this cycle
  logic full_match; // counter equals compare on all bits
  logic low_match; // low bytes equal
  logic low_wrap; // low byte of counter at zero
  logic full_wrap; // whole counter at zero
  logic freq_match; // low byte reaches the frequency match point
  logic fn_match; // match event of the function in force

  // split the flat mode word into named fields
  always_comb begin
    mode.capcomp_flag_irq_en = counter_array_mode_reg_i[ccmc_pkg::POS_IRQ_EN];
    mode.pulse_width_mod_en = counter_array_mode_reg_i[ccmc_pkg::POS_PWM_EN];
    mode.match_toggle_en = counter_array_mode_reg_i[ccmc_pkg::POS_TOGGLE_EN];
    mode.compare_match_en = counter_array_mode_reg_i[ccmc_pkg::POS_MATCH_EN];
    mode.fall_edge_capture_en = counter_array_mode_reg_i[ccmc_pkg::POS_FALL_CAP];
    mode.rise_edge_capture_en = counter_array_mode_reg_i[ccmc_pkg::POS_RISE_CAP];
    mode.pulse_width_wide_sel = counter_array_mode_reg_i[ccmc_pkg::POS_WIDE_SEL];
  end

  // edge detector on the module pin, frozen with the rest
  ccmc_edge_det u_pin_edge (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .clk_en_i (clk_en_i),
    .level_i (module_io_pin_i),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  // an edge counts only if its polarity is enabled
  always_comb begin
    cap_hit = (pin_fall & mode.fall_edge_capture_en)
            | (pin_rise & mode.rise_edge_capture_en);
  end

  // compare terms, evaluated only when the counter has advanced
  always_comb begin
    full_match = count_tick_i & (count_i == compare_i);
    low_match = count_tick_i & (count_i[NW-1:0] == compare_i[NW-1:0]);
    low_wrap = count_tick_i & (count_i[NW-1:0] == '0);
    full_wrap = count_tick_i & (count_i == '0);
    freq_match = count_tick_i & (count_i[NW-1:0] == freq_next_q);
  end

  // decode the output function from toggle, pwm and width bits
  always_comb begin
    if (mode.match_toggle_en && mode.pulse_width_mod_en) begin
      fn_d = ccmc_pkg::CCMC_FN_FREQ; // both set wins over plain toggle and pwm
    end else if (mode.pulse_width_mod_en) begin
      // width select picks the resolution
      fn_d = mode.pulse_width_wide_sel ? ccmc_pkg::CCMC_FN_PWM16 : ccmc_pkg::CCMC_FN_PWM8;
    end else if (mode.match_toggle_en) begin
      fn_d = ccmc_pkg::CCMC_FN_TOGGLE;
    end else begin
      fn_d = ccmc_pkg::CCMC_FN_OFF;
    end
    if (!clk_en_i) begin
      fn_d = fn_q; // frozen
    end
  end

  // match event seen by the flag, depends on the function in force
  always_comb begin
    case (fn_q)
      ccmc_pkg::CCMC_FN_PWM8: fn_match = low_match;
      ccmc_pkg::CCMC_FN_FREQ: fn_match = freq_match;
      default: fn_match = full_match;
    endcase
  end

  // pin level and frequency step
  // pwm sets the pin at the match and clears it at the wrap, so duty grows as compare falls
  always_comb begin
    pin_d = pin_q;
    freq_next_d = freq_next_q;
    case (fn_q)
      ccmc_pkg::CCMC_FN_OFF: begin
        pin_d = pin_q; // holds its last level while undriven
        freq_next_d = compare_i[NW-1:0];
      end
      ccmc_pkg::CCMC_FN_TOGGLE: begin
        if (full_match) begin
          pin_d = ~pin_q;
        end
        freq_next_d = compare_i[NW-1:0];
      end
      ccmc_pkg::CCMC_FN_PWM8: begin
        // 8-bit resolution on the low byte
        if (low_match) begin
          pin_d = 1'b1;
        end else if (low_wrap) begin
          pin_d = 1'b0;
        end
        freq_next_d = compare_i[NW-1:0];
      end
      ccmc_pkg::CCMC_FN_PWM16: begin
        // 16-bit resolution on the full counter
        if (full_match) begin
          pin_d = 1'b1;
        end else if (full_wrap) begin
          pin_d = 1'b0;
        end
        freq_next_d = compare_i[NW-1:0];
      end
      ccmc_pkg::CCMC_FN_FREQ: begin
        // toggle and advance the match point by the high byte
        if (freq_match) begin
          pin_d = ~pin_q;
          freq_next_d = freq_next_q + compare_i[CNT_W-1:CNT_W-NW];
        end
      end
      default: begin
        pin_d = ccmc_pkg::RST_PIN_LEVEL;
        freq_next_d = ccmc_pkg::RST_FREQ_NEXT;
      end
    endcase
    if (!clk_en_i) begin
      pin_d = pin_q;
      freq_next_d = freq_next_q;
    end
  end

  // capture register and strobe
  always_comb begin
    cap_d.value = cap_q.value;
    cap_d.valid = 1'b0;
    if (cap_hit) begin
      cap_d.value = count_i; // counter copied on the edge cycle
      cap_d.valid = 1'b1;
    end
    if (!clk_en_i) begin
      cap_d = cap_q;
    end
  end

  // flag: a set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    flag_d = flag_q;
    if (flag_clr_i) begin
      flag_d = 1'b0;
    end
    if (cap_hit) begin
      flag_d = 1'b1; // same cycle as the capture
    end
    if (mode.compare_match_en && fn_match) begin
      flag_d = 1'b1;
    end
    if (!clk_en_i) begin
      flag_d = flag_q;
    end
  end

  // state registers, no logic here
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fn_q <= ccmc_pkg::CCMC_FN_OFF;
      pin_q <= ccmc_pkg::RST_PIN_LEVEL;
      freq_next_q <= ccmc_pkg::RST_FREQ_NEXT;
      flag_q <= ccmc_pkg::RST_FLAG;
      cap_q.valid <= 1'b0;
      cap_q.value <= ccmc_pkg::RST_CAPTURE;
    end else begin
      fn_q <= fn_d;
      pin_q <= pin_d;
      freq_next_q <= freq_next_d;
      flag_q <= flag_d;
      cap_q <= cap_d;
    end
  end

  // outputs; the pin is driven only while an output function is in force
  assign module_io_pin_o = pin_q;
  assign module_io_pin_oe_o = (fn_q != ccmc_pkg::CCMC_FN_OFF);
  assign capcomp_flag_o = flag_q;
  assign irq_req_o = flag_q & mode.capcomp_flag_irq_en; // masked by bit 0
  assign capture_o = cap_q;

endmodule // ccmc_mode_ctrl

// ==== core/ccmc_pkg.sv ====
package ccmc_pkg;

  // default width of the shared counter and of the compare value
  localparam int unsigned CNT_W = 16;
  // width of the narrow pwm and of the frequency-output step
  localparam int unsigned NARROW_W = 8;

  // bit positions inside the per-module mode word
  localparam int unsigned MODE_W = 8;
  localparam int unsigned POS_IRQ_EN = 0;
  localparam int unsigned POS_PWM_EN = 1;
  localparam int unsigned POS_TOGGLE_EN = 2;
  localparam int unsigned POS_MATCH_EN = 3;
  localparam int unsigned POS_FALL_CAP = 4;
  localparam int unsigned POS_RISE_CAP = 5;
  localparam int unsigned POS_WIDE_SEL = 6;

  // reset values
  localparam logic RST_PIN_LEVEL = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [CNT_W-1:0] RST_CAPTURE = 16'h0000;
  localparam logic [NARROW_W-1:0] RST_FREQ_NEXT = 8'h00;

  // output function of the module, one-hot
  typedef enum logic [4:0] {
    CCMC_FN_OFF    = 5'h01,
    CCMC_FN_TOGGLE = 5'h02,
    CCMC_FN_PWM8   = 5'h04,
    CCMC_FN_PWM16  = 5'h08,
    CCMC_FN_FREQ   = 5'h10
  } ccmc_fn_e;

  // unpacked view of the mode word
  typedef struct packed {
    logic pulse_width_wide_sel;
    logic rise_edge_capture_en;
    logic fall_edge_capture_en;
    logic compare_match_en;
    logic match_toggle_en;
    logic pulse_width_mod_en;
    logic capcomp_flag_irq_en;
  } ccmc_mode_s;

  // captured counter value with its one-cycle strobe
  typedef struct packed {
    logic valid;
    logic [CNT_W-1:0] value;
  } ccmc_capture_s;

endpackage

// ==== core/ccmc_edge_det.sv ====
`timescale 1ns/1ps
// registers a synchronous level and flags its rising and falling edges
module ccmc_edge_det (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // sampled level
  input wire logic level_i,
  // edge pulses, combinational from the held level
  output logic rise_o,
  output logic fall_o
);

  logic level_q; // level seen on the previous enabled edge
  logic level_d; // next value of the held level

  // sample the level only while the clock enable is high, hold it while low
  always_comb begin
    level_d = level_q;
    if (clk_en_i) begin
      level_d = level_i;
    end
  end

  // plain register, no logic here
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  // a high pin at reset release counts as a rising edge; accepted on purpose
  assign rise_o = level_i & ~level_q;
  assign fall_o = ~level_i & level_q;

endmodule // ccmc_edge_det

// ==== tb/ccmc_asserts.sv ====
`timescale 1ns/1ps
// port-level checks of one capture/compare module
module ccmc_asserts #(
  parameter int unsigned CNT_W = ccmc_pkg::CNT_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // inputs of the module
  input wire logic [ccmc_pkg::MODE_W-1:0] counter_array_mode_reg_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic count_tick_i,
  input wire logic [CNT_W-1:0] compare_i,
  input wire logic module_io_pin_i,
  // outputs of the module
  input wire logic module_io_pin_o,
  input wire logic capcomp_flag_o,
  input wire logic irq_req_o,
  input wire ccmc_pkg::ccmc_capture_s capture_o
);
  // short views; checks on registered state ask for enabled edges, since a low enable freezes them
  wire logic [ccmc_pkg::MODE_W-1:0] m = counter_array_mode_reg_i;
  wire logic pw = m[1] & ~m[2] & count_tick_i;
  wire logic hit = m[6] ? count_i == compare_i : count_i[7:0] == compare_i[7:0];
  wire logic zro = m[6] ? count_i == 16'h0000 : count_i[7:0] == 8'h00;
  wire logic fmatch = count_tick_i & (count_i == compare_i);

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // edge history restarts at reset and holds while frozen, so both edges of the pair must be enabled
  property p_fall;
    $past(rst_b_i) && clk_en_i && $past(clk_en_i) && m[4] && $fell(module_io_pin_i)
      |=> capture_o.valid && capcomp_flag_o;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge not captured");
  property p_rise;
    $past(rst_b_i) && clk_en_i && $past(clk_en_i) && m[5] && $rose(module_io_pin_i)
      |=> capture_o.valid && capcomp_flag_o;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge not captured");
  // a strobe held through a frozen cycle no longer lines up with the counter
  property p_capval;
    capture_o.valid && $past(clk_en_i) |-> capture_o.value == $past(count_i);
  endproperty
  a_capval: assert property (p_capval) else $error("captured value wrong");
  // the function register lags the word by an enabled cycle, hence the stable word
  property p_match;
    m[3] && !m[1] && $stable(m) && clk_en_i && $past(clk_en_i) && fmatch |=> capcomp_flag_o;
  endproperty
  a_match: assert property (p_match) else $error("match did not set flag");
  property p_toggle;
    m[2] && !m[1] && $stable(m) && $past(rst_b_i) && clk_en_i && $past(clk_en_i) && fmatch
      |=> $changed(module_io_pin_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");
  property p_pwm_hi;
    pw && $stable(m) && $past(rst_b_i) && clk_en_i && $past(clk_en_i) && hit |=> module_io_pin_o;
  endproperty
  a_pwm_hi: assert property (p_pwm_hi) else $error("pwm pin not set");
  property p_pwm_lo;
    pw && $stable(m) && $past(rst_b_i) && clk_en_i && $past(clk_en_i) && zro && !hit
      |=> !module_io_pin_o;
  endproperty
  a_pwm_lo: assert property (p_pwm_lo) else $error("pwm pin not cleared");
  property p_irq; irq_req_o == (capcomp_flag_o && m[0]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");
endmodule // ccmc_asserts

bind ccmc_mode_ctrl ccmc_asserts #(.CNT_W(CNT_W)) chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i),
  .counter_array_mode_reg_i(counter_array_mode_reg_i), .count_i(count_i), .count_tick_i(count_tick_i),
  .compare_i(compare_i), .module_io_pin_i(module_io_pin_i), .module_io_pin_o(module_io_pin_o),
  .capcomp_flag_o(capcomp_flag_o), .irq_req_o(irq_req_o), .capture_o(capture_o));

// ==== tb/ccmc_pin_model.sv ====
`timescale 1ns/1ps
// external source and load on the module pin
module ccmc_pin_model (
  // pin as the board sees it
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  output logic pin_level_o
);
  logic src_level = 1'b0; // level the outside source drives
  // push-pull pin: the module wins whenever it drives
  assign pin_level_o = pin_oe_i ? pin_drive_i : src_level;
  task automatic set_level(input logic v);
    src_level = v;
  endtask
endmodule // ccmc_pin_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// directed bench for one capture/compare module
module tb_top;
  // stimulus and observed signals
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] mode = 8'h00;
  logic [15:0] cnt = 16'h0000;
  logic tk = 1'b0;
  logic [15:0] cmp = 16'h0000;
  logic clr = 1'b0;
  logic ce = 1'b1; // clock enable, low only in the freeze scenario
  logic pin_in, pin_out, pin_oe, flag, irq;
  ccmc_pkg::ccmc_capture_s cap;
  int bad_count = 0;
  int checks = 0;

  always #10 clock_i = ~clock_i;

  // clock enable is driven so that the freeze is exercised as well
  ccmc_mode_ctrl dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(ce),
    .counter_array_mode_reg_i(mode), .count_i(cnt), .count_tick_i(tk), .compare_i(cmp),
    .flag_clr_i(clr), .module_io_pin_i(pin_in), .module_io_pin_o(pin_out),
    .module_io_pin_oe_o(pin_oe), .capcomp_flag_o(flag), .irq_req_o(irq), .capture_o(cap));
  ccmc_pin_model pin_u (.pin_drive_i(pin_out), .pin_oe_i(pin_oe), .pin_level_o(pin_in));

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one counter tick, then the pin level it leaves
  task automatic tick_pin(input logic [15:0] c, input logic exp);
    cnt = c;
    tk = 1'b1;
    step(1);
    tk = 1'b0;
    chk({16'h0000, pin_out}, {16'h0000, exp});
  endtask
  task automatic t_capture;
    mode = 8'h10;
    pin_u.set_level(1'b1);
    step(1);
    chk(cap.valid, 1'b0);
    cnt = 16'h1234;
    pin_u.set_level(1'b0);
    step(1);
    chk({cap.valid, cap.value}, {1'b1, 16'h1234});
    chk(flag, 1'b1);
    mode = 8'h21;
    step(1);
    chk(cap.valid, 1'b0);
    chk(irq, 1'b1);
    cnt = 16'h5678;
    pin_u.set_level(1'b1);
    step(1);
    chk({cap.valid, cap.value}, {1'b1, 16'h5678});
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    chk({flag, irq}, 2'h0);
    mode = 8'h00;
    pin_u.set_level(1'b0);
    step(1);
    chk({cap.valid, flag}, 2'h0);
  endtask
  task automatic t_match;
    mode = 8'h0c;
    cmp = 16'h00ff;
    step(1);
    chk(pin_oe, 1'b1);
    tick_pin(16'h00ff, 1'b1);
    chk(flag, 1'b1);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    tick_pin(16'h01ff, 1'b1);
    chk(flag, 1'b0);
    mode = 8'h04;
    tick_pin(16'h00ff, 1'b0);
    chk(flag, 1'b0);
  endtask
  task automatic t_pwm;
    mode = 8'h0a;
    cmp = 16'h1280;
    step(1);
    tick_pin(16'h0080, 1'b1);
    tick_pin(16'h0100, 1'b0);
    mode = 8'h42;
    step(1);
    tick_pin(16'h0080, 1'b0);
    tick_pin(16'h1280, 1'b1);
    tick_pin(16'h0100, 1'b1);
    tick_pin(16'h0000, 1'b0);
    mode = 8'h00;
    step(1);
    chk(pin_oe, 1'b0);
  endtask
  // step 0x04 from point 0x10: plain toggle would also flip at 0x0410
  task automatic t_freq;
    mode = 8'h06;
    cmp = 16'h0410;
    step(1);
    tick_pin(16'h0010, 1'b1);
    tick_pin(16'h0410, 1'b1);
    tick_pin(16'h0014, 1'b0);
  endtask
  // clock enable low: a match tick during the freeze is lost, a pending capture edge waits, held state stays put
  task automatic t_freeze;
    ce = 1'b0;
    mode = 8'h00;
    cnt = 16'h0018;
    tk = 1'b1;
    step(1);
    tk = 1'b0;
    chk({pin_out, pin_oe}, 2'h1);
    ce = 1'b1;
    clr = 1'b1;
    pin_u.set_level(1'b1);
    step(1);
    clr = 1'b0;
    mode = 8'h10;
    step(1);
    chk({cap.valid, flag, pin_oe}, 3'h0);
    ce = 1'b0;
    cnt = 16'h4321;
    pin_u.set_level(1'b0);
    step(2);
    chk({cap.valid, flag}, 2'h0);
    ce = 1'b1;
    step(1);
    chk({cap.valid, cap.value}, {1'b1, 16'h4321});
    ce = 1'b0;
    step(2);
    chk({cap.valid, flag}, 2'h3);
    ce = 1'b1;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    chk({cap.valid, flag}, 2'h0);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    step(20);
    chk(cap, 17'h00000);
    chk({pin_out, pin_oe, flag, irq}, 4'h0);
    rst_b_i = 1'b1;
    t_capture;
    t_match;
    t_pwm;
    t_freq;
    t_freeze;
    end_of_test;
  end
endmodule // tb_top
